// >>> shared/aux_port_pkg.sv
// Contract
// - Terminal mode: pins zero-two configurable input/output.
// - GPIO read returns pin level, output drives register.
// - Line/network modes: pins zero-two select channel.
// - Pin three is always plain GPIO.
// - Pin four alternate: multiframe bit in/out by mode.
// - Pin five alternate outputs sync or halved data clock (not the line clock in line-terminal-T mode).
// - Config bit chooses sync or halved data clock.
// - Pin six raises maskable interrupt, edge or level.
// - Pin six open-drain or push-pull; pull-up only open-drain.
// - Host interrupt defaults active-low open-drain, reprogrammable.
// - Terminal mode bit clock is data clock halved.
// - Line-terminal-T bit clock is 1.536 MHz line clock.
// - Network/line-terminal-S bit clock is data clock halved.
package aux_port_pkg;
  localparam int         NUM_PINS      = 7;
  localparam logic [11:0] ADDR_DIR     = 12'h000;
  localparam logic [11:0] ADDR_OUT     = 12'h004;
  localparam logic [11:0] ADDR_IN      = 12'h008;
  localparam logic [11:0] ADDR_CFG     = 12'h00C;
  localparam logic [11:0] ADDR_STAT    = 12'h010;
  localparam logic [11:0] ADDR_MASK    = 12'h014;
  localparam logic [11:0] ADDR_MODE    = 12'h018;
  localparam int CFG_PIN4_ALT   = 0;
  localparam int CFG_PIN5_ALT   = 1;
  localparam int CFG_SYNC_CHOICE = 2;
  localparam int CFG_EDGE_TRIG  = 3;
  localparam int CFG_SIX_PUSH   = 4;
  localparam int CFG_IRQ_HIGH   = 5;
  localparam int CFG_WIDTH      = 6;
  localparam logic [6:0] DIR_RESET  = 7'h00;
  localparam logic [6:0] OUT_RESET  = 7'h00;
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 6'h00;
  localparam logic       MASK_RESET = 1'b1;
  typedef enum logic [1:0] {MODE_TE, MODE_LTT, MODE_LTS} op_mode_type;
endpackage

// >>> hw/pin_sync.sv
`timescale 1ns/100ps
module pin_sync (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Pin in, filtered level out.
  input  wire logic pinIn,
  output logic      level
);
  logic [2:0] stage_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_reg <= 3'h0;
    end else begin
      stage_reg <= {stage_reg[1:0], pinIn};
    end
  end

  // The second and third stages must agree before the level changes.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      level <= 1'b0;
    end else if (stage_reg[1] == stage_reg[2]) begin
      level <= stage_reg[2];
    end
  end
endmodule

// >>> hw/edge_toggle.sv
`timescale 1ns/100ps
module edge_toggle (
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Synchronised clock level in, halved clock and edge pulse out.
  input  wire logic clkLevel,
  output logic      halfClk,
  output logic      rise
);
  logic last_reg;

  assign rise = clkLevel & ~last_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_reg <= 1'b0;
    end else begin
      last_reg <= clkLevel;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      halfClk <= 1'b0;
    end else if (rise) begin
      halfClk <= ~halfClk;
    end
  end
endmodule

// >>> hw/aux_port.sv
`timescale 1ns/100ps
module aux_port (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Mode straps.
  input  wire logic        mode_select_first,
  input  wire logic        mode_select_second,
  // Serial highway clocks.
  input  wire logic        double_data_clock,
  input  wire logic        frame_sync,
  input  wire logic        line_clock,
  output logic             bit_clock_out,
  // Auxiliary pins, input, output and enable per pin.
  input  wire logic [6:0]  auxIn,
  output logic [6:0]       auxOut,
  output logic [6:0]       auxOe,
  output logic             sixPullupEn,
  // Multiframe bit to and from the framer.
  input  wire logic        multiframeBitTx,
  output logic             multiframeBitRx,
  // Channel select.
  output logic [2:0]       highway_channel_select,
  // Host interrupt pin.
  output logic             irqOut,
  output logic             irqOe
);
  logic [6:0] pinLevel;
  logic       modeFirst;
  logic       modeSecond;
  logic       dclLevel;
  logic       fscLevel;
  logic       lineLevel;
  logic       dclHalf;
  logic       dclRise;
  logic [6:0] dir_reg;
  logic [6:0] out_reg;
  logic [aux_port_pkg::CFG_WIDTH-1:0] cfg_reg;
  logic       stat_reg;
  logic       mask_reg;
  logic       sixLast_reg;
  logic       sixEvent;
  logic       irqPending;
  logic       wrEn;
  logic       rdEn;
  logic       addrOk;
  aux_port_pkg::op_mode_type mode;

  genvar g;
  generate
    for (g = 0; g < aux_port_pkg::NUM_PINS; g++) begin : gSync
      pin_sync uSync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pinIn   (auxIn[g]),
        .level   (pinLevel[g])
      );
    end
  endgenerate

  pin_sync uModeA (.sys_clk(sys_clk), .arst_n(arst_n), .pinIn(mode_select_first),  .level(modeFirst));
  pin_sync uModeB (.sys_clk(sys_clk), .arst_n(arst_n), .pinIn(mode_select_second), .level(modeSecond));
  pin_sync uDcl   (.sys_clk(sys_clk), .arst_n(arst_n), .pinIn(double_data_clock),  .level(dclLevel));
  pin_sync uFsc   (.sys_clk(sys_clk), .arst_n(arst_n), .pinIn(frame_sync),         .level(fscLevel));
  pin_sync uLine  (.sys_clk(sys_clk), .arst_n(arst_n), .pinIn(line_clock),         .level(lineLevel));

  edge_toggle uDiv (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .clkLevel (dclLevel),
    .halfClk  (dclHalf),
    .rise     (dclRise)
  );

  // Mode decode from the straps kept by the board.
  always_comb begin
    if (!modeFirst) begin
      mode = aux_port_pkg::MODE_TE;
    end else if (!modeSecond) begin
      mode = aux_port_pkg::MODE_LTT;
    end else begin
      mode = aux_port_pkg::MODE_LTS;
    end
  end

  // APB decode; every access completes with no wait state.
  assign pready  = 1'b1;
  assign wrEn    = psel & penable & pwrite;
  assign rdEn    = psel & ~pwrite;
  always_comb begin
    case (paddr)
      aux_port_pkg::ADDR_DIR,
      aux_port_pkg::ADDR_OUT,
      aux_port_pkg::ADDR_IN,
      aux_port_pkg::ADDR_CFG,
      aux_port_pkg::ADDR_STAT,
      aux_port_pkg::ADDR_MASK,
      aux_port_pkg::ADDR_MODE: addrOk = 1'b1;
      default:                 addrOk = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addrOk;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_reg <= aux_port_pkg::DIR_RESET;
    end else if (wrEn && paddr == aux_port_pkg::ADDR_DIR) begin
      dir_reg <= pwdata[6:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_reg <= aux_port_pkg::OUT_RESET;
    end else if (wrEn && paddr == aux_port_pkg::ADDR_OUT) begin
      out_reg <= pwdata[6:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= aux_port_pkg::CFG_RESET;
    end else if (wrEn && paddr == aux_port_pkg::ADDR_CFG) begin
      cfg_reg <= pwdata[aux_port_pkg::CFG_WIDTH-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= aux_port_pkg::MASK_RESET;
    end else if (wrEn && paddr == aux_port_pkg::ADDR_MASK) begin
      mask_reg <= pwdata[0];
    end
  end

  // Pin six event: rising edge or high level of the input.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sixLast_reg <= 1'b0;
    end else begin
      sixLast_reg <= pinLevel[6];
    end
  end
  assign sixEvent = cfg_reg[aux_port_pkg::CFG_EDGE_TRIG] ? (pinLevel[6] & ~sixLast_reg) : pinLevel[6];

  // Status is sticky, cleared by writing one; a new event wins over the clear.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_reg <= 1'b0;
    end else if (sixEvent) begin
      stat_reg <= 1'b1;
    end else if (wrEn && paddr == aux_port_pkg::ADDR_STAT && pwdata[0]) begin
      stat_reg <= 1'b0;
    end
  end

  assign irqPending = stat_reg & ~mask_reg;

  // Host interrupt pin: open-drain low by default, push-pull high when chosen.
  always_comb begin
    if (cfg_reg[aux_port_pkg::CFG_IRQ_HIGH]) begin
      irqOut = irqPending;
      irqOe  = 1'b1;
    end else begin
      irqOut = 1'b0;
      irqOe  = irqPending;
    end
  end

  // Read data.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (rdEn && !penable) begin
      case (paddr)
        aux_port_pkg::ADDR_DIR:  prdata <= {25'h0, dir_reg};
        aux_port_pkg::ADDR_OUT:  prdata <= {25'h0, out_reg};
        aux_port_pkg::ADDR_IN:   prdata <= {25'h0, pinLevel};
        aux_port_pkg::ADDR_CFG:  prdata <= {26'h0, cfg_reg};
        aux_port_pkg::ADDR_STAT: prdata <= {31'h0, stat_reg};
        aux_port_pkg::ADDR_MASK: prdata <= {31'h0, mask_reg};
        aux_port_pkg::ADDR_MODE: prdata <= {30'h0, mode};
        default:                 prdata <= 32'h00000000;
      endcase
    end
  end

  // Bit clock per mode.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_clock_out <= 1'b0;
    end else begin
      case (mode)
        aux_port_pkg::MODE_TE:  bit_clock_out <= dclHalf;
        aux_port_pkg::MODE_LTT: bit_clock_out <= lineLevel;
        aux_port_pkg::MODE_LTS: bit_clock_out <= dclHalf;
        default:                bit_clock_out <= dclHalf;
      endcase
    end
  end

  // Channel select, latched from pins zero-two outside terminal mode.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      highway_channel_select <= 3'h0;
    end else if (mode != aux_port_pkg::MODE_TE) begin
      highway_channel_select <= pinLevel[2:0];
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      multiframeBitRx <= 1'b0;
    end else begin
      multiframeBitRx <= pinLevel[4];
    end
  end

  // Pin drivers; open-drain pins drive low only, pin six may push-pull.
  always_comb begin
    auxOut = 7'h00;
    auxOe  = 7'h00;
    for (int i = 0; i < aux_port_pkg::NUM_PINS; i++) begin
      auxOe[i] = dir_reg[i] & ~out_reg[i];
    end
    if (mode != aux_port_pkg::MODE_TE) begin
      auxOe[2:0] = 3'h0;
    end
    auxOe[3] = dir_reg[3] & ~out_reg[3];
    if (cfg_reg[aux_port_pkg::CFG_PIN4_ALT]) begin
      if (mode == aux_port_pkg::MODE_LTS) begin
        auxOe[4] = 1'b0;
      end else begin
        auxOe[4] = ~multiframeBitTx;
      end
    end
    if (cfg_reg[aux_port_pkg::CFG_PIN5_ALT]) begin
      auxOe[5] = cfg_reg[aux_port_pkg::CFG_SYNC_CHOICE] ? ~dclHalf : ~fscLevel;
    end
    if (cfg_reg[aux_port_pkg::CFG_SIX_PUSH]) begin
      auxOut[6] = out_reg[6];
      auxOe[6]  = dir_reg[6];
    end
  end
  assign sixPullupEn = ~cfg_reg[aux_port_pkg::CFG_SIX_PUSH];

  mask_hides_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    mask_reg |-> !(irqOe && !cfg_reg[aux_port_pkg::CFG_IRQ_HIGH])) else $error("masked irq drives pin");
  sticky_stat_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    sixEvent |=> stat_reg) else $error("event lost");
  irq_low_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (irqPending && !cfg_reg[aux_port_pkg::CFG_IRQ_HIGH]) |-> (irqOe && !irqOut)) else $error("irq not low");
  irq_high_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    cfg_reg[aux_port_pkg::CFG_IRQ_HIGH] |-> (irqOe && irqOut == irqPending)) else $error("irq not high");
  chan_input_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (mode != aux_port_pkg::MODE_TE) |-> auxOe[2:0] == 3'h0) else $error("channel pins driven");
  chan_follow_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (mode != aux_port_pkg::MODE_TE) |=> highway_channel_select == $past(pinLevel[2:0])) else $error("channel wrong");
  pin3_gpio_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    auxOe[3] == (dir_reg[3] & ~out_reg[3])) else $error("pin three wrong");
  pullup_od_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    sixPullupEn |-> !auxOut[6]) else $error("pull-up in push-pull");
  multiframe_bit_pin_in_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cfg_reg[aux_port_pkg::CFG_PIN4_ALT] && mode == aux_port_pkg::MODE_LTS) |-> !auxOe[4]) else $error("multiframe_bit_pin driven");
  bclk_te_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (mode == aux_port_pkg::MODE_TE && $stable(mode)) |=> bit_clock_out == $past(dclHalf)) else $error("bclk wrong");

  irq_seen_c: cover property (@(posedge sys_clk) disable iff (!arst_n) irqPending);
  edge_mode_c: cover property (@(posedge sys_clk) disable iff (!arst_n) cfg_reg[aux_port_pkg::CFG_EDGE_TRIG] && sixEvent);
  div_edge_c: cover property (@(posedge sys_clk) disable iff (!arst_n) dclRise);
  alt_five_c: cover property (@(posedge sys_clk) disable iff (!arst_n) cfg_reg[aux_port_pkg::CFG_PIN5_ALT] && auxOe[5]);
endmodule

// >>> test/aux_pins_model.sv
`timescale 1ns/100ps
module aux_pins_model (
  // Design side of the pins.
  input  wire logic [6:0] auxOut,
  input  wire logic [6:0] auxOe,
  input  wire logic       sixPullupEn,
  // External drivers on the board.
  input  wire logic [6:0] extVal,
  input  wire logic [6:0] extOe,
  // Resolved pin levels and board clocks.
  output logic [6:0]      pins,
  output logic            dataClk,
  output logic            lineClk
);
  initial begin
    dataClk = 1'b0;
    forever #325.5 dataClk = ~dataClk;
  end
  initial begin
    lineClk = 1'b0;
    #100;
    forever #325.5 lineClk = ~lineClk;
  end
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      if (auxOe[i]) begin
        pins[i] = auxOut[i];
      end else if (extOe[i]) begin
        pins[i] = extVal[i];
      end else if (i < 6 || sixPullupEn) begin
        pins[i] = 1'b1;
      end else begin
        pins[i] = ~auxOut[i];
      end
    end
  end
endmodule

// >>> test/auxiliary_port_pin_functions_test.sv
`timescale 1ns/100ps
module auxiliary_port_pin_functions_test;
  logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, errSeen;
  logic        modeSelectFirst, modeSelectSecond, frameSync, mbTx, mbRx, bitClockOut;
  logic        irqOut, irqOe, pullEn, dataClk, lineClk;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [6:0]  pins, auxOut, auxOe, extVal, extOe;
  logic [2:0]  chan;
  int          n_errors, compares;

  aux_port u_aux_port (
    .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_select_first(modeSelectFirst), .mode_select_second(modeSelectSecond),
    .double_data_clock(dataClk), .frame_sync(frameSync), .line_clock(lineClk),
    .bit_clock_out(bitClockOut), .auxIn(pins), .auxOut(auxOut), .auxOe(auxOe),
    .sixPullupEn(pullEn), .multiframeBitTx(mbTx), .multiframeBitRx(mbRx),
    .highway_channel_select(chan), .irqOut(irqOut), .irqOe(irqOe)
  );
  aux_pins_model u_aux_pins_model (
    .auxOut(auxOut), .auxOe(auxOe), .sixPullupEn(pullEn), .extVal(extVal),
    .extOe(extOe), .pins(pins), .dataClk(dataClk), .lineClk(lineClk)
  );

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish;
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rdat = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rdat, e);
  endtask

  task automatic setMode(input logic f, input logic s);
    modeSelectFirst <= f;
    modeSelectSecond <= s;
    wt(6);
  endtask

  task automatic rises(input logic s, input int lo, input int hi);
    int n;
    logic p, v;
    n = 0;
    p = 1'b1;
    repeat (1302) begin
      @(posedge sys_clk);
      v = s ? pins[5] : bitClockOut;
      if (v === 1'b1 && p === 1'b0) n++;
      p = v;
    end
    check("rises", n >= lo && n <= hi, 1'b1);
  endtask

  task automatic resetValues;
    rd(aux_port_pkg::ADDR_DIR, 32'h0);
    rd(aux_port_pkg::ADDR_CFG, 32'h0);
    rd(aux_port_pkg::ADDR_MASK, 32'h1);
    rd(aux_port_pkg::ADDR_MODE, 32'h0);
    check("irqOe", irqOe, 1'b0);
    check("pull", pullEn, 1'b1);
  endtask

  task automatic gpioPins;
    wr(aux_port_pkg::ADDR_DIR, 32'h7F);
    wr(aux_port_pkg::ADDR_OUT, 32'h55);
    wt(6);
    check("pins", pins, 7'h55);
    rd(aux_port_pkg::ADDR_IN, 32'h55);
    wr(aux_port_pkg::ADDR_DIR, 32'h0);
    extOe <= 7'h7F;
    extVal <= 7'h2A;
    wt(6);
    rd(aux_port_pkg::ADDR_IN, 32'h2A);
  endtask

  task automatic channelSelect;
    setMode(1'b1, 1'b0);
    rd(aux_port_pkg::ADDR_MODE, 32'h1);
    extOe <= 7'h07;
    extVal <= 7'h05;
    wr(aux_port_pkg::ADDR_DIR, 32'h07);
    wt(6);
    check("chan", chan, 3'h5);
    check("oe", auxOe[2:0], 3'h0);
    setMode(1'b1, 1'b1);
    rd(aux_port_pkg::ADDR_MODE, 32'h2);
    extVal <= 7'h03;
    wt(6);
    check("chan", chan, 3'h3);
  endtask

  task automatic multiframe;
    wr(aux_port_pkg::ADDR_CFG, 32'h1);
    extOe <= 7'h10;
    extVal <= 7'h10;
    wt(6);
    check("mbRx", mbRx, 1'b1);
    extVal <= 7'h00;
    wt(6);
    check("mbRx", mbRx, 1'b0);
    extOe <= 7'h00;
    setMode(1'b0, 1'b0);
    check("pin4", pins[4], 1'b0);
    mbTx <= 1'b1;
    wt(6);
    check("pin4", pins[4], 1'b1);
    wr(aux_port_pkg::ADDR_CFG, 32'h0);
    wr(aux_port_pkg::ADDR_DIR, 32'h10);
    wr(aux_port_pkg::ADDR_OUT, 32'h0);
    check("pin4", pins[4], 1'b0);
  endtask

  task automatic clocks;
    rises(1'b0, 7, 9);
    wr(aux_port_pkg::ADDR_CFG, 32'h6);
    rises(1'b1, 7, 9);
    wr(aux_port_pkg::ADDR_CFG, 32'h2);
    frameSync <= 1'b1;
    wt(6);
    check("pin5", pins[5], 1'b1);
    frameSync <= 1'b0;
    wt(6);
    check("pin5", pins[5], 1'b0);
    setMode(1'b1, 1'b0);
    rises(1'b0, 15, 17);
    setMode(1'b1, 1'b1);
    rises(1'b0, 7, 9);
    setMode(1'b0, 1'b0);
    wr(aux_port_pkg::ADDR_CFG, 32'h0);
    check("pin5", pins[5], 1'b1);
  endtask

  task automatic pinSixIrq;
    extOe <= 7'h40;
    extVal <= 7'h40;
    wt(6);
    rd(aux_port_pkg::ADDR_STAT, 32'h1);
    check("irqOe", irqOe, 1'b0);
    wr(aux_port_pkg::ADDR_STAT, 32'h1);
    rd(aux_port_pkg::ADDR_STAT, 32'h1);
    extVal <= 7'h00;
    wt(6);
    wr(aux_port_pkg::ADDR_STAT, 32'h1);
    rd(aux_port_pkg::ADDR_STAT, 32'h0);
    wr(aux_port_pkg::ADDR_MASK, 32'h0);
    extVal <= 7'h40;
    wt(6);
    check("irq", {irqOe, irqOut}, 2'b10);
    wr(aux_port_pkg::ADDR_CFG, 32'h28);
    check("irq", {irqOe, irqOut}, 2'b11);
    wr(aux_port_pkg::ADDR_STAT, 32'h1);
    check("irq", {irqOe, irqOut}, 2'b10);
    extVal <= 7'h00;
    wt(6);
    extVal <= 7'h40;
    wt(6);
    check("irq", {irqOe, irqOut}, 2'b11);
    extOe <= 7'h00;
    wr(aux_port_pkg::ADDR_CFG, 32'h10);
    wr(aux_port_pkg::ADDR_DIR, 32'h40);
    wr(aux_port_pkg::ADDR_OUT, 32'h40);
    check("pull", pullEn, 1'b0);
    check("six", {auxOe[6], auxOut[6]}, 2'b11);
    wr(aux_port_pkg::ADDR_CFG, 32'h0);
    check("pull", pullEn, 1'b1);
  endtask

  task automatic badAddress;
    apb(1'b0, 12'h020, 32'h0);
    check("slverr", errSeen, 1'b1);
    check("rdat", rdat, 32'h0);
  endtask

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    modeSelectFirst = 1'b0;
    modeSelectSecond = 1'b0;
    frameSync = 1'b0;
    mbTx = 1'b0;
    extVal = 7'h00;
    extOe = 7'h00;
    n_errors = 0;
    compares = 0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    resetValues();
    gpioPins();
    channelSelect();
    multiframe();
    clocks();
    pinSixIrq();
    badAddress();
    tally_and_finish();
  end
endmodule
